// >>> phy_power_eee_ctrl.sv
// transceiver end: power-down states and transmit low-power idle detection
`timescale 1ns/1ns
`include "phy_pwr_consts.svh"
module phy_power_eee_ctrl
	import phy_pwr_pkg::*;
#(
	parameter int REFRESH_PERIOD_CYC = `REFRESH_PERIOD_US * `SYS_CLK_MHZ
) (
	// clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// link
	rgmii_lpi_if.device_end link,
	// control bits
	input  wire logic       pd_ctrl,
	input  wire logic       clk_gate_override,
	input  wire logic       pll_disable,
	input  wire logic       oscillator_off,
	input  wire logic       isolate_ctrl,
	input  wire logic       ref_clock_out_en,
	input  wire logic       regulator_ctrl_en_n,
	input  wire logic       negotiation_restart,
	input  wire logic       adv_eee_1000,
	input  wire logic       adv_eee_100,
	input  wire logic       clock_stop_en,
	input  wire logic       speed_1000,
	input  wire logic       rx_lpi_in,
	input  wire logic [3:0] mode_strap,
	// status and clock controls
	output logic            spd_state,
	output logic            chip_powerdown_state,
	output logic            hs_clk_run,
	output logic            pll_on,
	output logic            osc_on,
	output logic            regulator_on,
	output logic            tx_clk_run,
	output logic            rx_clk_run,
	output logic            ref_clock_out_pin,
	output logic            mgmt_std_ok,
	output logic            mgmt_mmd_ok,
	output logic            mgmt_mmd1_ok,
	output logic            full_reset,
	output logic            eee_enabled,
	output logic            tx_lpi,
	output logic            rx_lpi,
	output logic            refresh_active
);
	localparam int REFRESH_BURST_CYC = `REFRESH_BURST_US * `SYS_CLK_MHZ;

	pwr_state_t state;
	pwr_state_t next_state;
	logic       strap_done;
	logic       in_spd;
	logic       keep_clk;
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic       txc_d;
	logic       rise;
	logic       fall;
	logic       en_r;
	logic [3:0] lo_r;
	logic       lpi_now;
	logic [17:0] ref_cnt;

	function automatic logic lpi_rise(input logic ctl, input nibble_t n);
		lpi_rise = !ctl && (n == `LPI_LO_NIBBLE);
	endfunction : lpi_rise

	// power state sequencing
	always_comb begin
		next_state = state;
		case (state)
			PWR_ACTIVE: begin
				if (!strap_done && mode_strap == `CPD_STRAP) begin
					next_state = PWR_CHIP_DOWN;
				end else if (pd_ctrl) begin
					next_state = pll_disable ? PWR_SPD_PLL_OFF : PWR_SPD;
				end
			end
			PWR_SPD: begin
				if (!pd_ctrl) begin
					next_state = PWR_ACTIVE;
				end
			end
			PWR_SPD_PLL_OFF: begin
				if (oscillator_off) begin
					next_state = PWR_OSC_OFF;
				end else if (!pd_ctrl) begin
					next_state = PWR_ACTIVE;
				end
			end
			PWR_OSC_OFF: begin
				next_state = PWR_OSC_OFF;
			end
			PWR_CHIP_DOWN: begin
				next_state = PWR_CHIP_DOWN;
			end
			default: begin
				next_state = PWR_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state      <= PWR_ACTIVE;
			strap_done <= 1'b0;
			full_reset <= 1'b0;
		end else if (ce) begin
			state      <= next_state;
			strap_done <= 1'b1;
			full_reset <= (state == PWR_SPD_PLL_OFF) && (next_state == PWR_ACTIVE);
		end
	end

	assign in_spd   = (state == PWR_SPD) || (state == PWR_SPD_PLL_OFF)
		|| (state == PWR_OSC_OFF);
	assign keep_clk = !in_spd || clk_gate_override;

	// registered clock and access controls
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			spd_state            <= 1'b0;
			chip_powerdown_state <= 1'b0;
			hs_clk_run           <= 1'b0;
			pll_on               <= 1'b1;
			osc_on               <= 1'b1;
			regulator_on         <= 1'b1;
			tx_clk_run           <= 1'b0;
			rx_clk_run           <= 1'b0;
			ref_clock_out_pin    <= 1'b0;
			mgmt_std_ok          <= 1'b1;
			mgmt_mmd_ok          <= 1'b0;
			mgmt_mmd1_ok         <= 1'b0;
		end else if (ce) begin
			spd_state            <= in_spd;
			chip_powerdown_state <= (state == PWR_CHIP_DOWN);
			hs_clk_run   <= keep_clk && (state != PWR_CHIP_DOWN);
			pll_on       <= (state == PWR_ACTIVE) || (state == PWR_SPD);
			osc_on       <= (state != PWR_OSC_OFF) && (state != PWR_CHIP_DOWN);
			regulator_on <= !regulator_ctrl_en_n && (state != PWR_CHIP_DOWN);
			tx_clk_run        <= keep_clk && !isolate_ctrl && (state != PWR_CHIP_DOWN);
			rx_clk_run        <= keep_clk && !isolate_ctrl && (state != PWR_CHIP_DOWN);
			ref_clock_out_pin <= keep_clk && ref_clock_out_en && (state != PWR_CHIP_DOWN);
			mgmt_std_ok  <= (state != PWR_OSC_OFF) && (state != PWR_CHIP_DOWN);
			mgmt_mmd_ok  <= (state == PWR_ACTIVE)
				|| ((state == PWR_SPD || state == PWR_SPD_PLL_OFF) && clk_gate_override);
			mgmt_mmd1_ok <= (state == PWR_ACTIVE);
		end
	end

	// eee on from reset, follows advertisement on restart
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			eee_enabled <= 1'b1;
		end else if (ce && negotiation_restart) begin
			eee_enabled <= adv_eee_1000 || adv_eee_100;
		end
	end

	// link pins: two-flop synchroniser
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pin_s1 <= 6'h00;
			pin_s2 <= 6'h00;
			txc_d  <= 1'b0;
		end else if (ce) begin
			pin_s1 <= {link.txc, link.tx_ctl, link.txd};
			pin_s2 <= pin_s1;
			txc_d  <= pin_s2[5];
		end
	end

	assign rise = pin_s2[5] && !txc_d;
	assign fall = !pin_s2[5] && txc_d;

	// enable and low nibble on rise, rest on fall
	// 100 mbps ignores the falling nibble
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			en_r <= 1'b0;
			lo_r <= `IDLE_NIBBLE;
		end else if (ce && rise) begin
			en_r <= pin_s2[4];
			lo_r <= pin_s2[3:0];
		end
	end

	assign lpi_now = lpi_rise(en_r, lo_r) && pin_s2[4]
		&& (!speed_1000 || pin_s2[3:0] == `LPI_HI_NIBBLE);

	// transmit idle tracked on its own
	// no edges, no change: halted txc stays idle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tx_lpi <= 1'b0;
		end else if (ce) begin
			if (!eee_enabled || state != PWR_ACTIVE) begin
				tx_lpi <= 1'b0;
			// any changed rising value ends idle at once
			end else if (rise && !lpi_rise(pin_s2[4], pin_s2[3:0])) begin
				tx_lpi <= 1'b0;
			end else if (fall) begin
				tx_lpi <= lpi_now;
			end
		end
	end

	// receive idle from the line side, separate flag
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rx_lpi <= 1'b0;
		end else if (ce) begin
			rx_lpi <= rx_lpi_in && eee_enabled && (state == PWR_ACTIVE);
		end
	end

	// refresh burst then quiet, repeating while idle
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ref_cnt        <= 18'h0_0000;
			refresh_active <= 1'b0;
		end else if (ce) begin
			if (!tx_lpi) begin
				ref_cnt        <= 18'h0_0000;
				refresh_active <= 1'b0;
			end else begin
				if (ref_cnt == 18'(REFRESH_PERIOD_CYC - 1)) begin
					ref_cnt <= 18'h0_0000;
				end else begin
					ref_cnt <= ref_cnt + 18'h0_0001;
				end
				refresh_active <= (ref_cnt < 18'(REFRESH_BURST_CYC))
					&& (ref_cnt != 18'(REFRESH_PERIOD_CYC - 1));
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			link.clk_stop_ok <= 1'b0;
		end else if (ce) begin
			link.clk_stop_ok <= clock_stop_en && eee_enabled;
		end
	end

endmodule : phy_power_eee_ctrl

// >>> phy_pwr_consts.svh
// timing, pattern and strap constants for power and low-power idle control
`ifndef PHY_PWR_CONSTS_SVH
`define PHY_PWR_CONSTS_SVH

`define SYS_CLK_MHZ        10
`define REFRESH_PERIOD_US  20000
`define REFRESH_BURST_US   200
`define LPI_LO_NIBBLE      4'h1
`define LPI_HI_NIBBLE      4'h0
`define IDLE_NIBBLE        4'h0
`define CPD_STRAP          4'h7
`define LPI_STOP_CYCLES    4'hA
`define TXC_RISE_PH        3'h7
`define TXC_FALL_PH        3'h3
`define TXC_SETUP_RISE_PH  3'h5
`define TXC_SETUP_FALL_PH  3'h1
`define TXC_STOP_PH        3'h4

`endif

// >>> phy_pwr_pkg.sv
// types shared by the power and low-power idle ends
package phy_pwr_pkg;

	typedef enum logic [2:0] {
		PWR_ACTIVE,
		PWR_SPD,
		PWR_SPD_PLL_OFF,
		PWR_OSC_OFF,
		PWR_CHIP_DOWN
	} pwr_state_t;

	typedef logic [3:0] nibble_t;

endpackage : phy_pwr_pkg

// >>> rgmii_lpi_if.sv
// transmit side of the rgmii link between mac and transceiver
`timescale 1ns/1ns
interface rgmii_lpi_if;
	logic       txc;
	logic       tx_ctl;
	logic [3:0] txd;
	logic       clk_stop_ok;

	modport device_end (
		input  txc,
		input  tx_ctl,
		input  txd,
		output clk_stop_ok
	);

	modport mac_end (
		output txc,
		output tx_ctl,
		output txd,
		input  clk_stop_ok
	);
endinterface : rgmii_lpi_if

// >>> rgmii_mac_lpi_tx.sv
// mac end: makes txc, drives tx_ctl and txd, stops txc in low-power idle
`timescale 1ns/1ns
`include "phy_pwr_consts.svh"
module rgmii_mac_lpi_tx
	import phy_pwr_pkg::*;
(
	// clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// link
	rgmii_lpi_if.mac_end    link,
	// user side
	input  wire logic       speed_1000,
	input  wire logic       clock_stop_en,
	input  wire logic       lpi_req,
	input  wire logic       tx_valid,
	input  wire logic       tx_error,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            txc_stopped
);
	logic [2:0] ph;
	logic       txc;
	logic       ctl;
	logic [3:0] txd;
	logic       en_q;
	logic       er_q;
	logic [7:0] byte_q;
	logic [3:0] lpi_cnt;
	logic       stop_s1;
	logic       stop_s2;
	logic       stop_now;

	assign link.txc    = txc;
	assign link.tx_ctl = ctl;
	assign link.txd    = txd;

	assign stop_now = lpi_req && (lpi_cnt == `LPI_STOP_CYCLES) && stop_s2
		&& clock_stop_en && (ph == `TXC_STOP_PH);

	// clock-stop capability arrives from the far end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			stop_s1 <= 1'b0;
			stop_s2 <= 1'b0;
		end else if (ce) begin
			stop_s1 <= link.clk_stop_ok;
			stop_s2 <= stop_s1;
		end
	end

	// txc divider, frozen while stopped
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ph          <= 3'h0;
			txc         <= 1'b0;
			txc_stopped <= 1'b0;
		end else if (ce) begin
			if (txc_stopped) begin
				txc_stopped <= lpi_req;
			end else if (stop_now) begin
				txc_stopped <= 1'b1;
			end else begin
				ph <= ph + 3'h1;
				if (ph == `TXC_RISE_PH) begin
					txc <= 1'b1;
				end else if (ph == `TXC_FALL_PH) begin
					txc <= 1'b0;
				end
			end
		end
	end

	// enable and low nibble before rise, error and high before fall
	// 100 mbps repeats the low nibble
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			en_q     <= 1'b0;
			er_q     <= 1'b0;
			byte_q   <= 8'h00;
			ctl      <= 1'b0;
			txd      <= `IDLE_NIBBLE;
			tx_ready <= 1'b0;
		end else if (ce) begin
			tx_ready <= 1'b0;
			if (!txc_stopped && ph == `TXC_SETUP_RISE_PH) begin
				if (lpi_req) begin
					en_q   <= 1'b0;
					er_q   <= 1'b1;
					byte_q <= {`LPI_HI_NIBBLE, `LPI_LO_NIBBLE};
					ctl    <= 1'b0;
					txd    <= `LPI_LO_NIBBLE;
				end else begin
					en_q     <= tx_valid;
					er_q     <= tx_valid && tx_error;
					byte_q   <= tx_valid ? tx_data : 8'h00;
					ctl      <= tx_valid;
					txd      <= tx_valid ? tx_data[3:0] : `IDLE_NIBBLE;
					tx_ready <= tx_valid;
				end
			end else if (!txc_stopped && ph == `TXC_SETUP_FALL_PH) begin
				ctl <= er_q;
				txd <= speed_1000 ? byte_q[7:4] : byte_q[3:0];
			end
		end
	end

	// idle rising edges counted up to the stop threshold
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lpi_cnt <= 4'h0;
		end else if (ce) begin
			if (!lpi_req || !(!en_q && er_q)) begin
				lpi_cnt <= 4'h0;
			end else if (!txc_stopped && ph == `TXC_RISE_PH
					&& lpi_cnt != `LPI_STOP_CYCLES) begin
				lpi_cnt <= lpi_cnt + 4'h1;
			end
		end
	end

endmodule : rgmii_mac_lpi_tx

// >>> phy_power_eee_assertions.sv
// concurrent checks on the transmit link and the power status outputs
`timescale 1ns/1ns
module phy_power_eee_checker (
	// clock, reset
	input wire logic       sys_clk,
	input wire logic       rstn,
	// link
	input wire logic       txc,
	input wire logic       tx_ctl,
	input wire logic [3:0] txd,
	input wire logic       clk_stop_ok,
	// device status
	input wire logic       eee_enabled,
	input wire logic       tx_lpi,
	input wire logic       refresh_active,
	input wire logic       spd_state,
	input wire logic       mgmt_mmd1_ok,
	input wire logic       chip_powerdown_state,
	input wire logic       full_reset
);
	logic [11:0] low_cnt;
	logic [11:0] burst_cnt;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// cycles with txc low
	always_ff @(posedge sys_clk) begin
		if (!rstn || txc) low_cnt <= '0;
		else if (low_cnt != 12'hfff) low_cnt <= low_cnt + 12'h001;
	end

	// length of the current refresh burst
	always_ff @(posedge sys_clk) begin
		if (!rstn || !refresh_active) burst_cnt <= '0;
		else burst_cnt <= burst_cnt + 12'h001;
	end

	chk_txc_high_time: assert property ($rose(txc) |-> txc[*4] ##1 !txc)
		else $error("txc high time wrong");
	chk_ctl_rise_setup: assert property ($rose(txc) |-> $stable(tx_ctl) && $stable(txd))
		else $error("ctl or data moved at txc rise");
	chk_ctl_fall_setup: assert property ($fell(txc) |-> $stable(tx_ctl) && $stable(txd))
		else $error("ctl or data moved at txc fall");
	chk_stop_needs_ok: assert property ((low_cnt > 12'h000a) |-> clk_stop_ok)
		else $error("txc halted without clock stop permission");
	chk_stop_ok_eee: assert property (clk_stop_ok |-> $past(eee_enabled))
		else $error("clock stop allowed with eee off");
	chk_space_one_off: assert property (spd_state |-> !mgmt_mmd1_ok)
		else $error("space one reachable in power-down");
	chk_chip_down_sticks: assert property (chip_powerdown_state |=> chip_powerdown_state)
		else $error("chip power-down left without reset");
	chk_reset_one_pulse: assert property (full_reset |=> !full_reset)
		else $error("full reset longer than one cycle");
	chk_refresh_in_idle: assert property (refresh_active |-> $past(tx_lpi))
		else $error("refresh outside idle");
	chk_burst_length: assert property (($fell(refresh_active) && tx_lpi) |-> burst_cnt == 12'h07d0)
		else $error("refresh burst length wrong");

	cover property ($rose(tx_lpi));
	cover property (low_cnt == 12'h0020);
	cover property ($rose(spd_state));
	cover property (full_reset);
endmodule : phy_power_eee_checker

// >>> phy_power_down_eee_lpi_ctrl_tb.sv
// self-checking bench for both ends of the transmit idle link
`timescale 1ns/1ns
module phy_power_down_eee_lpi_ctrl_tb;
	localparam int PERIOD = 6000;
	logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic pd_ctrl, clk_gate_override, pll_disable, oscillator_off, isolate_ctrl;
	logic ref_clock_out_en, regulator_ctrl_en_n, negotiation_restart, clock_stop_en;
	logic adv_eee_1000, adv_eee_100, speed_1000, rx_lpi_in, lpi_req, tx_valid, tx_error;
	logic [3:0] mode_strap;
	logic [7:0] tx_data;
	logic spd_state, chip_powerdown_state, hs_clk_run, pll_on, osc_on, regulator_on;
	logic tx_clk_run, rx_clk_run, ref_clock_out_pin, mgmt_std_ok, mgmt_mmd_ok;
	logic mgmt_mmd1_ok, full_reset, eee_enabled, tx_lpi, rx_lpi, refresh_active;
	logic tx_ready, txc_stopped;
	int   n_fail = 0, compares = 0, n_fr = 0, n_rdy = 0, n_rf;

	rgmii_lpi_if i_rgmii_lpi_if ();
	phy_power_eee_ctrl #(.REFRESH_PERIOD_CYC(PERIOD)) i_phy_power_eee_ctrl (
		.link(i_rgmii_lpi_if), .*);
	rgmii_mac_lpi_tx i_rgmii_mac_lpi_tx (.link(i_rgmii_lpi_if), .*);
	phy_power_eee_checker i_phy_power_eee_checker (.txc(i_rgmii_lpi_if.txc),
		.tx_ctl(i_rgmii_lpi_if.tx_ctl), .txd(i_rgmii_lpi_if.txd),
		.clk_stop_ok(i_rgmii_lpi_if.clk_stop_ok), .*);

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (full_reset === 1'b1) n_fr++;
		if (tx_ready === 1'b1) n_rdy++;
	end

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : step

	task automatic chk(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %b want %b", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset();
		rstn = 1'b0;
		step(5);
		rstn = 1'b1;
		step(3);
	endtask : do_reset

	task automatic wait_lpi(input logic v);
		for (int i = 0; i < 400 && tx_lpi !== v; i++) step(1);
	endtask : wait_lpi

	task automatic summarize();
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize

	initial begin
		#2_000_000;
		n_fail++;
		summarize();
	end

	initial begin
		{pd_ctrl, clk_gate_override, pll_disable, oscillator_off, isolate_ctrl} = '0;
		{ref_clock_out_en, regulator_ctrl_en_n, negotiation_restart, clock_stop_en} = '0;
		{rx_lpi_in, lpi_req, tx_valid, tx_error} = '0;
		{adv_eee_1000, adv_eee_100, speed_1000} = 3'b111;
		mode_strap = 4'h0;
		tx_data = 8'h00;
		do_reset();
		chk(eee_enabled, 1'b1);
		// power-down, no override
		pd_ctrl = 1'b1;
		step(3);
		chk(spd_state, 1'b1);
		chk(hs_clk_run, 1'b0);
		chk(pll_on & osc_on & mgmt_std_ok, 1'b1);
		chk(mgmt_mmd_ok | mgmt_mmd1_ok, 1'b0);
		chk(tx_clk_run | rx_clk_run | ref_clock_out_pin, 1'b0);
		pd_ctrl = 1'b0;
		step(3);
		chk(spd_state, 1'b0);
		chk(hs_clk_run, 1'b1);
		chk(n_fr == 0, 1'b1);
		// power-down with override
		{clk_gate_override, ref_clock_out_en, pd_ctrl} = 3'b111;
		step(3);
		chk(hs_clk_run & tx_clk_run & rx_clk_run, 1'b1);
		chk(ref_clock_out_pin & mgmt_mmd_ok, 1'b1);
		chk(mgmt_mmd1_ok, 1'b0);
		{isolate_ctrl, ref_clock_out_en} = 2'b10;
		step(3);
		chk(tx_clk_run | rx_clk_run | ref_clock_out_pin, 1'b0);
		{clk_gate_override, isolate_ctrl, pd_ctrl} = '0;
		regulator_ctrl_en_n = 1'b1;
		step(3);
		chk(regulator_on, 1'b0);
		// pll and oscillator savings
		{regulator_ctrl_en_n, pll_disable, pd_ctrl} = 3'b011;
		step(3);
		chk(pll_on, 1'b0);
		pd_ctrl = 1'b0;
		step(4);
		chk(n_fr == 1, 1'b1);
		pd_ctrl = 1'b1;
		step(3);
		oscillator_off = 1'b1;
		step(3);
		pd_ctrl = 1'b0;
		step(4);
		chk(osc_on | mgmt_std_ok, 1'b0);
		{oscillator_off, pll_disable} = '0;
		do_reset();
		chk(osc_on, 1'b1);
		// gigabit idle, refresh, clock stop, wake
		lpi_req = 1'b1;
		wait_lpi(1'b1);
		chk(tx_lpi, 1'b1);
		chk(rx_lpi, 1'b0);
		n_rf = 0;
		repeat (5000) begin
			step(1);
			if (refresh_active === 1'b1) n_rf++;
		end
		chk(n_rf == 2000, 1'b1);
		rx_lpi_in = 1'b1;
		step(3);
		chk(rx_lpi & tx_lpi, 1'b1);
		rx_lpi_in = 1'b0;
		clock_stop_en = 1'b1;
		step(200);
		chk(txc_stopped & tx_lpi, 1'b1);
		{lpi_req, tx_valid, tx_data} = {2'b01, 8'h55};
		wait_lpi(1'b0);
		chk(tx_lpi, 1'b0);
		n_rdy = 0;
		step(40);
		chk(n_rdy > 0 && txc_stopped === 1'b0, 1'b1);
		{tx_valid, clock_stop_en} = '0;
		// 100 Mbps idle
		{speed_1000, lpi_req} = 2'b01;
		wait_lpi(1'b1);
		chk(tx_lpi, 1'b1);
		lpi_req = 1'b0;
		wait_lpi(1'b0);
		chk(tx_lpi, 1'b0);
		// eee switched off
		{adv_eee_1000, adv_eee_100, negotiation_restart} = 3'b001;
		step(1);
		negotiation_restart = 1'b0;
		step(2);
		chk(eee_enabled, 1'b0);
		lpi_req = 1'b1;
		step(200);
		chk(tx_lpi, 1'b0);
		lpi_req = 1'b0;
		// strap into chip power-down
		mode_strap = 4'h7;
		do_reset();
		pd_ctrl = 1'b1;
		step(3);
		pd_ctrl = 1'b0;
		step(3);
		chk(chip_powerdown_state & !regulator_on, 1'b1);
		mode_strap = 4'h0;
		do_reset();
		chk(chip_powerdown_state, 1'b0);
		summarize();
	end
endmodule : phy_power_down_eee_lpi_ctrl_tb
